//--- tfd_map.svh
// constants for the temperature readout and fan output block
`ifndef TFD_MAP_SVH
`define TFD_MAP_SVH

// *********************************************************
// clock and measurement timing
// *********************************************************
`define TFD_CLK_PERIOD_NS   25
`define TFD_MEAS_TIME_NS    9_600_000
`define TFD_AVG_COUNT       16
`define TFD_AVG_SHIFT       4
`define TFD_PHASES_PER_MEAS 32

// *********************************************************
// register fields and reset values
// *********************************************************
`define TFD_FAN_CODE_RST    8'h00
`define TFD_CFG_DIODE2_BIT  7
`define TFD_TEMP_RST        8'h00

`endif

//--- tfd_pkg.sv
// types shared by the temperature readout and fan output block
package tfd_pkg;

  typedef logic signed [7:0] tfd_temp_t;

  typedef logic signed [11:0] tfd_acc_t;

  typedef enum logic [0:0]
  {
    TFD_EXC_LOW  = 1'b0,
    TFD_EXC_HIGH = 1'b1
  } tfd_state_t;

endpackage : tfd_pkg

//--- tfd_avg_if.sv
// carrier between the sequencer and the averager
interface tfd_avg_if;
  import tfd_pkg::*;

  logic      add;
  tfd_temp_t sample;
  logic      done;
  tfd_temp_t result;

  modport seq (output add, output sample, input done, input result);
  modport avg (input add, input sample, output done, output result);

endinterface : tfd_avg_if

//--- tfd_avg.sv
// sixteen-sample averager for raw temperature readings
`include "tfd_map.svh"

module tfd_avg
  import tfd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // sequencer side
  tfd_avg_if.avg   av
);

  localparam logic [3:0] CNT_LAST = 4'(`TFD_AVG_COUNT - 1);

  logic [3:0] cnt_q;
  tfd_acc_t   acc_q;
  tfd_acc_t   sum;

  assign sum = acc_q + tfd_acc_t'(av.sample);

  // *********************************************************
  // accumulate and publish
  // *********************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q     <= 4'h0;
      acc_q     <= 12'h000;
      av.done   <= 1'b0;
      av.result <= `TFD_TEMP_RST;
    end
    else
    begin
      av.done <= 1'b0;
      if (av.add)
      begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == CNT_LAST)
        begin
          // arithmetic shift keeps two's complement sign
          acc_q     <= 12'h000;                                  // RQ2
          av.result <= tfd_temp_t'(sum >>> `TFD_AVG_SHIFT);      // RQ1
          av.done   <= 1'b1;
        end
        else
        begin
          acc_q <= sum;
        end
      end
    end
  end

  // *********************************************************
  // checks
  // *********************************************************
  a_avg_sixteen_adds: assert property (        // RQ2
    @(posedge clk) disable iff (!rst_b)
    av.done |-> $past(cnt_q) == CNT_LAST && $past(av.add) && cnt_q == 4'h0)
    else $error("average published without sixteen samples");

endmodule : tfd_avg

//--- tfd_top.sv
// remote-diode readout sequencer and fan level output
`include "tfd_map.svh"

// Overview of operation
// RQ1: each result is an 8-bit two's complement value, one degree per count.
// RQ2: each external result is the average of sixteen raw measurement cycles.
// RQ3: one full averaged measurement takes nominally 9.6 ms.
// RQ4: the diode excitation alternates between the base and multiple current.
// RQ5: the fan level output follows an unsigned 8-bit code set by software.
// RQ6: the fan code register resets to zero, giving minimum fan speed.
// RQ7: a separate fan gate output switches the fan regardless of the code.
// RQ8: configuration bit 7 turns the second pin pair into a second diode input.
// RQ9: a temperature register only changes once a full average completes.
module tfd_top
  import tfd_pkg::*;
#(
  parameter int MEAS_CYCLES = `TFD_MEAS_TIME_NS / `TFD_CLK_PERIOD_NS
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // raw converter reading, same clock
  input  wire tfd_temp_t  adc_data,
  // fan code register write port
  input  wire logic       fan_code_wr,
  input  wire logic [7:0] fan_code_wdata,
  // configuration register and fan gate request
  input  wire logic [7:0] cfg_wdata,
  input  wire logic       cfg_wr,
  input  wire logic       fan_gate_on,
  // remote sensor control
  output logic            exc_high_q,
  output logic            chan_sel_q,
  output logic            pair2_diode_q,
  // results
  output tfd_temp_t       temp_ext1_q,
  output tfd_temp_t       temp_ext2_q,
  output logic            temp_new_q,
  // fan outputs
  output logic [7:0]      fan_level_output,
  output logic            fan_run_q
);

  localparam int PHASE_CYC = MEAS_CYCLES / `TFD_PHASES_PER_MEAS;
  localparam logic [18:0] PHASE_LAST = 19'(PHASE_CYC - 1);

  tfd_avg_if  avg_bus ();
  tfd_state_t state_q;
  logic [18:0] phase_cnt_q;
  logic        phase_end;

  assign phase_end = (phase_cnt_q == PHASE_LAST);

  // *********************************************************
  // excitation phase timer
  // *********************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      phase_cnt_q <= 19'h0_0000;
    else if (phase_end)
      phase_cnt_q <= 19'h0_0000;
    else
      phase_cnt_q <= phase_cnt_q + 19'h0_0001;
  end

  // *********************************************************
  // current switching state
  // *********************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= TFD_EXC_LOW;
    else if (phase_end)
    begin
      unique case (state_q)
        TFD_EXC_LOW:  state_q <= TFD_EXC_HIGH;                   // RQ4
        TFD_EXC_HIGH: state_q <= TFD_EXC_LOW;                    // RQ4
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      exc_high_q <= 1'b0;
    else
      exc_high_q <= (phase_end ? (state_q == TFD_EXC_LOW)
                               : (state_q == TFD_EXC_HIGH));     // RQ4
  end

  // one raw cycle ends after the multiple-current phase
  assign avg_bus.add    = phase_end && (state_q == TFD_EXC_HIGH);
  assign avg_bus.sample = adc_data;

  tfd_avg tfd_avg_i
  (
    .clk   (clk),
    .rst_b (rst_b),
    .av    (avg_bus.avg)
  );

  // *********************************************************
  // second pin pair role
  // *********************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pair2_diode_q <= 1'b0;
    else if (cfg_wr)
      pair2_diode_q <= cfg_wdata[`TFD_CFG_DIODE2_BIT];           // RQ8
  end

  // channel advances only between whole measurements
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      chan_sel_q <= 1'b0;
    else if (!pair2_diode_q)
      chan_sel_q <= 1'b0;                                        // RQ8
    else if (avg_bus.done)
      chan_sel_q <= !chan_sel_q;                                 // RQ8
  end

  // *********************************************************
  // result registers
  // *********************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      temp_ext1_q <= `TFD_TEMP_RST;
      temp_ext2_q <= `TFD_TEMP_RST;
      temp_new_q  <= 1'b0;
    end
    else
    begin
      temp_new_q <= avg_bus.done;                                // RQ3
      if (avg_bus.done && !chan_sel_q)
        temp_ext1_q <= avg_bus.result;                           // RQ9
      if (avg_bus.done && chan_sel_q)
        temp_ext2_q <= avg_bus.result;                           // RQ9
    end
  end

  // *********************************************************
  // fan code register and gate
  // *********************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fan_level_output <= `TFD_FAN_CODE_RST;                     // RQ6
    else if (fan_code_wr)
      fan_level_output <= fan_code_wdata;                        // RQ5
  end

  // gate acts alone, the code is left as written
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fan_run_q <= 1'b0;
    else
      fan_run_q <= fan_gate_on;                                  // RQ7
  end

  // *********************************************************
  // checks
  // *********************************************************
  logic [18:0] gap_q;
  logic [1:0]  seen_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_q  <= 19'h0_0000;
      seen_q <= 2'h0;
    end
    else if (temp_new_q)
    begin
      gap_q  <= 19'h0_0001;
      seen_q <= (seen_q == 2'h2) ? seen_q : seen_q + 2'h1;
    end
    else
      gap_q <= gap_q + 19'h0_0001;
  end

  // done arrives while no publish pulse is pending
  sequence s_done_with_result;
    avg_bus.done ##0 !temp_new_q;
  endsequence

  // publish flag stands for exactly one cycle
  sequence s_published;
    temp_new_q ##1 !temp_new_q;
  endsequence

  a_result_captured: assert property (          // RQ1
    @(posedge clk) disable iff (!rst_b)
    (avg_bus.done && !chan_sel_q) |=>
      temp_ext1_q == $past(avg_bus.result))
    else $error("channel one result not captured");

  a_result_publish: assert property (           // RQ2
    @(posedge clk) disable iff (!rst_b)
    s_done_with_result |=> s_published)
    else $error("completed average not flagged");

  a_meas_period: assert property (              // RQ3
    @(posedge clk) disable iff (!rst_b)
    (temp_new_q && seen_q == 2'h2) |-> gap_q == 19'(MEAS_CYCLES))
    else $error("measurement period wrong");

  a_exc_switch_time: assert property (          // RQ4
    @(posedge clk) disable iff (!rst_b)
    $changed(exc_high_q) |-> $past(phase_end))
    else $error("excitation switched mid phase");

  a_fan_code_write: assert property (           // RQ5
    @(posedge clk) disable iff (!rst_b)
    fan_code_wr |=> fan_level_output == $past(fan_code_wdata))
    else $error("fan code not stored");

  a_fan_reset_zero: assert property (           // RQ6
    @(posedge clk)
    $rose(rst_b) |-> fan_level_output == `TFD_FAN_CODE_RST)
    else $error("fan code not zero after reset");

  a_gate_independent: assert property (         // RQ7
    @(posedge clk) disable iff (!rst_b)
    ($changed(fan_run_q) && !$past(fan_code_wr)) |->
      $stable(fan_level_output))
    else $error("fan gate disturbed fan code");

  a_pair2_channel: assert property (            // RQ8
    @(posedge clk) disable iff (!rst_b)
    !$past(pair2_diode_q) |-> !chan_sel_q)
    else $error("second channel used while pins in default role");

  a_no_partial: assert property (               // RQ9
    @(posedge clk) disable iff (!rst_b)
    ($changed(temp_ext1_q) || $changed(temp_ext2_q)) |->
      $past(avg_bus.done))
    else $error("temperature changed without full average");

endmodule : tfd_top

//--- tfd_sensor_model.sv
// behavioural remote diode and fan drive facing the block
module tfd_sensor_model
  import tfd_pkg::*;
(
  // excitation and channel from the block
  exc_high_q,
  chan_sel_q,
  // true temperature per channel
  base0,
  base1,
  // fan outputs from the block
  fan_level_output,
  fan_run_q,
  // converter reading and fan drive
  adc_data,
  fan_drive
);
  input  wire logic       exc_high_q;
  input  wire logic       chan_sel_q;
  input  wire tfd_temp_t  base0;
  input  wire tfd_temp_t  base1;
  input  wire logic [7:0] fan_level_output;
  input  wire logic       fan_run_q;
  output tfd_temp_t       adc_data;
  output logic [7:0]      fan_drive;

  logic      odd;
  tfd_temp_t level;

  // readings alternate base-1 and base, so a floor average gives base-1
  initial odd = 1'b0;
  always @(negedge exc_high_q) odd <= ~odd;
  assign level = chan_sel_q ? base1 : base0;
  // garbage outside the high phase
  assign adc_data = !exc_high_q ? ~level : (odd ? level : level - 8'sh01);
  // gate cuts the drive whatever the code
  assign fan_drive = fan_run_q ? fan_level_output : 8'h00;
endmodule : tfd_sensor_model

//--- tfd_top_tb_top.sv
// self-checking bench for the readout and fan block
module tfd_top_tb_top;
  import tfd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, rst_b, fan_code_wr, cfg_wr, fan_gate_on;
  logic [7:0] fan_code_wdata, cfg_wdata, fan_level_output, fan_drive;
  logic       exc_high_q, chan_sel_q, pair2_diode_q, temp_new_q, fan_run_q;
  tfd_temp_t  adc_data, temp_ext1_q, temp_ext2_q, base0, base1;
  int         n_mismatch, n_tests, cyc, rises;
  logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFE, 8'hFF};
  tfd_temp_t  bases[4] = '{8'sh00, 8'sh81, 8'sh64, 8'sh7F};

  tfd_top #(.MEAS_CYCLES(64)) tfd_top_i (.clk(clk), .rst_b(rst_b),
    .adc_data(adc_data), .fan_code_wr(fan_code_wr),
    .fan_code_wdata(fan_code_wdata), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .fan_gate_on(fan_gate_on), .exc_high_q(exc_high_q),
    .chan_sel_q(chan_sel_q), .pair2_diode_q(pair2_diode_q),
    .temp_ext1_q(temp_ext1_q), .temp_ext2_q(temp_ext2_q),
    .temp_new_q(temp_new_q), .fan_level_output(fan_level_output),
    .fan_run_q(fan_run_q));

  tfd_sensor_model tfd_sensor_model_i (.exc_high_q(exc_high_q),
    .chan_sel_q(chan_sel_q), .base0(base0), .base1(base1),
    .fan_level_output(fan_level_output), .fan_run_q(fan_run_q),
    .adc_data(adc_data), .fan_drive(fan_drive));

  // *****************************************************
  // tasks
  // *****************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic is_cfg, input logic [7:0] d);
    @(negedge clk);
    fan_code_wr = !is_cfg;
    cfg_wr = is_cfg;
    fan_code_wdata = d;
    cfg_wdata = d;
    @(negedge clk);
    fan_code_wr = 1'b0;
    cfg_wr = 1'b0;
  endtask : wr

  // steps to the next result, watching excitation and held values
  task automatic wait_result;
    tfd_temp_t held1, held2;
    logic      last;
    held1 = temp_ext1_q;
    held2 = temp_ext2_q;
    last = exc_high_q;
    cyc = 0;
    rises = 0;
    do
    begin
      @(negedge clk);
      cyc++;
      if (exc_high_q && !last)
        rises++;
      last = exc_high_q;
      if (temp_new_q !== 1'b1)
      begin
        check(temp_ext1_q, held1);
        check(temp_ext2_q, held2);
      end
    end
    while (temp_new_q !== 1'b1 && cyc < 200);
    check(8'(cyc < 200), 8'h01);
  endtask : wait_result

  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // *****************************************************
  // clock, watchdog and tests
  // *****************************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    rst_b = 1'b0;
    {fan_code_wr, cfg_wr, fan_gate_on} = 3'b000;
    fan_code_wdata = 8'h00;
    cfg_wdata = 8'h00;
    base0 = 8'sh00;
    base1 = 8'shCE;
    n_mismatch = 0;
    n_tests = 0;
    repeat (12) @(negedge clk);
    check(fan_level_output, 8'h00);
    rst_b = 1'b1;
    foreach (codes[i])
    begin
      wr(1'b0, codes[i]);
      check(fan_level_output, codes[i]);
      check(fan_drive, 8'h00);
    end
    fan_gate_on = 1'b1;
    @(negedge clk);
    check(fan_run_q, 1'b1);
    check(fan_drive, 8'hFF);
    wr(1'b0, 8'h40);
    fan_gate_on = 1'b0;
    @(negedge clk);
    check(fan_run_q, 1'b0);
    check(fan_level_output, 8'h40);
    check(fan_drive, 8'h00);
    wr(1'b1, 8'h7F);
    check(pair2_diode_q, 1'b0);
    wr(1'b1, 8'h80);
    check(pair2_diode_q, 1'b1);
    wr(1'b1, 8'h00);
    check(pair2_diode_q, 1'b0);
    wait_result();
    foreach (bases[i])
    begin
      base0 = bases[i];
      wait_result();
      check(8'(cyc), 8'h40);
      check(8'(rises), 8'h10);
      check(temp_ext1_q, bases[i] - 8'sh01);
    end
    base0 = 8'sh19;
    wr(1'b1, 8'h80);
    wait_result();
    check(temp_ext1_q, 8'sh18);
    check(chan_sel_q, 1'b1);
    wait_result();
    check(temp_ext2_q, 8'shCD);
    stop_test();
  end
endmodule : tfd_top_tb_top
